/* dpcs_consts.vh */
// Purpose: constants of the pll control, status and host pin block
// Assumes: 50 MHz reference clock, 8-bit register address and data
// Notes:   definitions only
// Overview of operation
// - A low level on the reset input puts the block into reset.
// - Hitless enable high: reference switches of pll one give no phase hit.
// - Hitless enable low: switches realign pll one phase to the new reference.
// - A software register bit can also enable or disable hitless switching.
// - Mode pins sampled during reset set pll one default mode.
// - After reset mode follows pin changes or writes to register 0x1f.
// - Lock output high only while pll one is frequency and phase locked.
// - Holdover output high while pll one is in holdover.
// - Reference output is a buffered copy of pll two's selected reference.
// - Interface select 0: shared pins act as spi clock, in, out, chip select.
// - Interface select 1: pins act as i2c scl/sda plus address selects.
// - I2c engine enabled when select high, spi engine when low.
`ifndef DPCS_CONSTS_VH
`define DPCS_CONSTS_VH
`define DPCS_CLK_NS        20
`define DPCS_RST_MIN_NS    300
`define DPCS_RST_MIN_CYC   ((`DPCS_RST_MIN_NS + `DPCS_CLK_NS - 1) / `DPCS_CLK_NS)
// register offsets
`define DPCS_OFS_MODE      8'h1f
`define DPCS_OFS_HITLESS   8'h20
`define DPCS_OFS_STATUS    8'h21
// hitless control fields
`define DPCS_HS_SW_VAL_BIT 0
`define DPCS_HS_SW_SEL_BIT 1
`define DPCS_HS_RESET      2'h0
// pll one modes
`define DPCS_MODE_AUTO     2'h0
`define DPCS_MODE_NORMAL   2'h1
`define DPCS_MODE_HOLD     2'h2
`define DPCS_MODE_FREE     2'h3
// i2c slave address upper bits, arbitrary value
`define DPCS_I2C_ADDR_HI   4'h6
// i2c engine states
`define DPCS_I2C_IDLE      2'h0
`define DPCS_I2C_DEV       2'h1
`define DPCS_I2C_REG       2'h2
`define DPCS_I2C_DATA      2'h3
`endif

/* dpcs_top.v */
// Purpose: pin level control, status and spi/i2c host port of pll one/two
// Assumes: all pins already synchronous to REF_CLK_I
// Notes:   open-drain enables are active low (low = pulling pin low)
`timescale 1ns/10ps
`default_nettype none
`include "dpcs_consts.vh"
module dpcs_top #(
    parameter NREF = 8,
    parameter SELW = 3
) (
    input  wire            REF_CLK_I,
    input  wire            RST_N_I,
    input  wire            HITLESS_SWITCH_ENABLE_I,
    input  wire            PLL_MODE_PIN_BIT0_I,
    input  wire            PLL_MODE_PIN_BIT1_I,
    input  wire            PLL_LOCKED_I,
    input  wire            PLL_HOLDOVER_I,
    input  wire            REF_SWITCH_I,
    input  wire [NREF-1:0] REFS_I,
    input  wire [SELW-1:0] PLL_TWO_REF_SEL_I,
    input  wire            I2C_ENABLE_I,
    input  wire            SCK_SCL_I,
    input  wire            SI_SDA_I,
    input  wire            CHIP_SELECT_OR_ADDR_BIT0_I,
    input  wire            BUS_ADDR_PICK_BIT1_I,
    input  wire            BUS_ADDR_PICK_BIT2_I,
    output reg  [1:0]      PLL_ONE_MODE_O,
    output reg             HITLESS_SWITCH_O,
    output reg             PHASE_REALIGN_O,
    output reg             LOCK_O,
    output reg             HOLD_O,
    output reg             REF_OUT_O,
    output reg             SO_O,
    output reg             SCL_O,
    output reg             SCL_OE_N_O,
    output reg             SDA_O,
    output reg             SDA_OE_N_O
);
    reg  [1:0] mode_reg;
    reg  [1:0] mode_pin_q_reg;
    reg  [1:0] hs_ctl_reg;
    reg        sck_q_reg;
    reg        sda_q_reg;
    reg  [4:0] spi_cnt_reg;
    reg  [7:0] spi_sh_reg;
    reg  [7:0] spi_tx_reg;
    reg  [6:0] spi_addr_reg;
    reg        spi_rd_reg;
    reg  [1:0] i2c_st_reg;
    reg  [3:0] i2c_cnt_reg;
    reg  [7:0] i2c_sh_reg;
    reg  [7:0] i2c_tx_reg;
    reg  [7:0] i2c_ptr_reg;
    reg  [2:0] i2c_asel_reg;
    reg        i2c_ack_reg;
    reg        i2c_rd_reg;
    reg        sda_drive_reg;
    reg        wr_en;
    reg  [7:0] wr_addr;
    reg  [7:0] wr_data;
    wire [1:0] mode_pins;
    wire       hs_eff;
    wire       sck_rise;
    wire       sck_fall;
    wire       sda_rise;
    wire       sda_fall;
    wire       cs_n;
    wire [7:0] i2c_rd_byte;

    assign mode_pins = {PLL_MODE_PIN_BIT1_I, PLL_MODE_PIN_BIT0_I};
    // software select bit overrides the pin when set
    assign hs_eff = hs_ctl_reg[`DPCS_HS_SW_SEL_BIT] ?
                    hs_ctl_reg[`DPCS_HS_SW_VAL_BIT] :
                    HITLESS_SWITCH_ENABLE_I;
    // shared pin edges; one sampler serves both engines
    assign sck_rise = SCK_SCL_I & ~sck_q_reg;
    assign sck_fall = ~SCK_SCL_I & sck_q_reg;
    assign sda_rise = SI_SDA_I & ~sda_q_reg;
    assign sda_fall = ~SI_SDA_I & sda_q_reg;
    assign cs_n = CHIP_SELECT_OR_ADDR_BIT0_I;

    // register read mux; unmapped offsets read zero
    function [7:0] rd_data;
        input [7:0] a;
        begin
            case (a)
                `DPCS_OFS_MODE:    rd_data = {6'h00, mode_reg};
                `DPCS_OFS_HITLESS: rd_data = {6'h00, hs_ctl_reg};
                `DPCS_OFS_STATUS:  rd_data = {4'h0, hs_eff, HOLD_O, LOCK_O,
                                              I2C_ENABLE_I};
                default:           rd_data = 8'h00;
            endcase
        end
    endfunction

    // byte at the i2c pointer, loaded into the transmit shifter
    assign i2c_rd_byte = rd_data(i2c_ptr_reg);

    // write port shared by the two engines
    always @* begin
        wr_en = 1'b0;
        wr_addr = 8'h00;
        wr_data = 8'h00;
        if (!I2C_ENABLE_I) begin
            // spi write completes on the 16th rising clock edge
            if (!cs_n && sck_rise && !spi_rd_reg && spi_cnt_reg == 5'h0f) begin
                wr_en = 1'b1;
                // shifter holds data bits by now, so use the held address
                wr_addr = {1'b0, spi_addr_reg};
                wr_data = {spi_sh_reg[6:0], SI_SDA_I};
            end
        end else if (sck_fall && !i2c_ack_reg && i2c_cnt_reg == 4'h8 &&
                     i2c_st_reg == `DPCS_I2C_DATA && !i2c_rd_reg) begin
            wr_en = 1'b1;
            wr_addr = i2c_ptr_reg;
            wr_data = i2c_sh_reg;
        end
    end

    // mode, hitless control and status outputs
    always @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            mode_reg <= mode_pins;
            mode_pin_q_reg <= mode_pins;
            hs_ctl_reg <= `DPCS_HS_RESET;
            PLL_ONE_MODE_O <= mode_pins;
            HITLESS_SWITCH_O <= 1'b0;
            PHASE_REALIGN_O <= 1'b0;
            LOCK_O <= 1'b0;
            HOLD_O <= 1'b0;
            REF_OUT_O <= 1'b0;
        end else begin
            mode_pin_q_reg <= mode_pins;
            // latest source wins; a write beats a pin change in one cycle
            if (wr_en && wr_addr == `DPCS_OFS_MODE)
                mode_reg <= wr_data[1:0];
            else if (mode_pins != mode_pin_q_reg)
                mode_reg <= mode_pins;
            if (wr_en && wr_addr == `DPCS_OFS_HITLESS)
                hs_ctl_reg <= wr_data[1:0];
            PLL_ONE_MODE_O <= mode_reg;
            // switch request goes to hitless or realign path
            HITLESS_SWITCH_O <= REF_SWITCH_I & hs_eff;
            PHASE_REALIGN_O <= REF_SWITCH_I & ~hs_eff;
            // no lock claimed while the loop is not tracking
            LOCK_O <= PLL_LOCKED_I && (mode_reg == `DPCS_MODE_AUTO ||
                                       mode_reg == `DPCS_MODE_NORMAL);
            HOLD_O <= (mode_reg == `DPCS_MODE_HOLD) ||
                      (mode_reg == `DPCS_MODE_AUTO && PLL_HOLDOVER_I);
            // one flop delay only; glitches at a switch are allowed
            REF_OUT_O <= REFS_I[PLL_TWO_REF_SEL_I];
        end
    end

    // spi engine: r/w bit, 7 address bits, 8 data bits, msb first
    always @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            sck_q_reg <= 1'b0;
            spi_cnt_reg <= 5'h00;
            spi_sh_reg <= 8'h00;
            spi_tx_reg <= 8'h00;
            spi_addr_reg <= 7'h00;
            spi_rd_reg <= 1'b0;
            SO_O <= 1'b0;
        end else begin
            sck_q_reg <= SCK_SCL_I;
            if (I2C_ENABLE_I || cs_n) begin
                // deselect or i2c mode parks the engine; so pin unused
                spi_cnt_reg <= 5'h00;
                spi_rd_reg <= 1'b0;
                SO_O <= 1'b0;
            end else begin
                if (sck_rise) begin
                    spi_sh_reg <= {spi_sh_reg[6:0], SI_SDA_I};
                    if (spi_cnt_reg != 5'h10)
                        spi_cnt_reg <= spi_cnt_reg + 5'h01;
                    if (spi_cnt_reg == 5'h00)
                        spi_rd_reg <= SI_SDA_I;
                    if (spi_cnt_reg == 5'h07) begin
                        spi_addr_reg <= {spi_sh_reg[5:0], SI_SDA_I};
                        spi_tx_reg <= rd_data({1'b0, spi_sh_reg[5:0],
                                               SI_SDA_I});
                    end
                end
                // read data leaves on falling edges after the address
                if (sck_fall && spi_rd_reg && spi_cnt_reg >= 5'h08 &&
                    spi_cnt_reg < 5'h10) begin
                    SO_O <= spi_tx_reg[7];
                    spi_tx_reg <= {spi_tx_reg[6:0], 1'b0};
                end
            end
        end
    end

    // i2c engine: dev address, register pointer, data bytes
    always @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            sda_q_reg <= 1'b1;
            i2c_st_reg <= `DPCS_I2C_IDLE;
            i2c_cnt_reg <= 4'h0;
            i2c_sh_reg <= 8'h00;
            i2c_tx_reg <= 8'h00;
            i2c_ptr_reg <= 8'h00;
            i2c_asel_reg <= 3'h0;
            i2c_ack_reg <= 1'b0;
            i2c_rd_reg <= 1'b0;
            sda_drive_reg <= 1'b0;
            SDA_O <= 1'b0;
            SDA_OE_N_O <= 1'b1;
            SCL_O <= 1'b0;
            SCL_OE_N_O <= 1'b1;
        end else begin
            sda_q_reg <= SI_SDA_I;
            SDA_O <= 1'b0;
            SCL_O <= 1'b0;
            SCL_OE_N_O <= 1'b1;      // no clock stretching is ever needed
            SDA_OE_N_O <= ~sda_drive_reg;
            if (!I2C_ENABLE_I) begin
                i2c_st_reg <= `DPCS_I2C_IDLE;
                sda_drive_reg <= 1'b0;
            end else if (SCK_SCL_I && sda_fall) begin
                // start or repeated start; address pins frozen here
                i2c_st_reg <= `DPCS_I2C_DEV;
                i2c_cnt_reg <= 4'h0;
                i2c_ack_reg <= 1'b0;
                sda_drive_reg <= 1'b0;
                i2c_asel_reg <= {BUS_ADDR_PICK_BIT2_I, BUS_ADDR_PICK_BIT1_I,
                                 CHIP_SELECT_OR_ADDR_BIT0_I};
            end else if (SCK_SCL_I && sda_rise) begin
                i2c_st_reg <= `DPCS_I2C_IDLE;
                sda_drive_reg <= 1'b0;
            end else if (i2c_st_reg != `DPCS_I2C_IDLE) begin
                if (sck_rise) begin
                    if (!i2c_ack_reg) begin
                        i2c_sh_reg <= {i2c_sh_reg[6:0], SI_SDA_I};
                        i2c_cnt_reg <= i2c_cnt_reg + 4'h1;
                    end else if (i2c_rd_reg && SI_SDA_I &&
                                 i2c_st_reg == `DPCS_I2C_DATA) begin
                        i2c_st_reg <= `DPCS_I2C_IDLE; // master nack ends read
                    end
                end
                if (sck_fall) begin
                    if (!i2c_ack_reg && i2c_cnt_reg == 4'h8) begin
                        i2c_ack_reg <= 1'b1;
                        sda_drive_reg <= 1'b1;
                        case (i2c_st_reg)
                            `DPCS_I2C_DEV: begin
                                if (i2c_sh_reg[7:1] !=
                                    {`DPCS_I2C_ADDR_HI, i2c_asel_reg}) begin
                                    i2c_st_reg <= `DPCS_I2C_IDLE;
                                    sda_drive_reg <= 1'b0;
                                end
                                i2c_rd_reg <= i2c_sh_reg[0];
                            end
                            `DPCS_I2C_REG: begin
                                i2c_ptr_reg <= i2c_sh_reg;
                                i2c_st_reg <= `DPCS_I2C_DATA;
                            end
                            `DPCS_I2C_DATA: begin
                                // read: master acks, we release the line
                                if (i2c_rd_reg)
                                    sda_drive_reg <= 1'b0;
                                else
                                    i2c_ptr_reg <= i2c_ptr_reg + 8'h01;
                            end
                            default: sda_drive_reg <= 1'b0;
                        endcase
                    end else if (i2c_ack_reg) begin
                        i2c_ack_reg <= 1'b0;
                        i2c_cnt_reg <= 4'h0;
                        sda_drive_reg <= 1'b0;
                        if (i2c_st_reg == `DPCS_I2C_DEV)
                            i2c_st_reg <= i2c_rd_reg ? `DPCS_I2C_DATA :
                                                       `DPCS_I2C_REG;
                        if (i2c_rd_reg && i2c_st_reg != `DPCS_I2C_REG) begin
                            sda_drive_reg <= ~i2c_rd_byte[7];
                            i2c_tx_reg <= i2c_rd_byte;
                            i2c_ptr_reg <= i2c_ptr_reg + 8'h01;
                        end
                    end else if (i2c_rd_reg && i2c_st_reg == `DPCS_I2C_DATA &&
                                 i2c_cnt_reg < 4'h8) begin
                        sda_drive_reg <= ~i2c_tx_reg[6];
                        i2c_tx_reg <= {i2c_tx_reg[6:0], 1'b0};
                    end
                end
            end
        end
    end
endmodule // dpcs_top
`default_nettype wire

/* dpcs_checker.sv */
// Purpose: port assertions for the pll control and host pin block
// Assumes: one clock, synchronous active-low reset
// Notes:   outputs are registered, so each lags its cause by at least one clock
`timescale 1ns/10ps
`default_nettype none
`include "dpcs_consts.vh"
module dpcs_checker #(
    parameter NREF = 8,
    parameter SELW = 3
) (
    input wire logic            REF_CLK_I,
    input wire logic            RST_N_I,
    input wire logic            PLL_MODE_PIN_BIT0_I,
    input wire logic            PLL_MODE_PIN_BIT1_I,
    input wire logic            PLL_LOCKED_I,
    input wire logic            REF_SWITCH_I,
    input wire logic [NREF-1:0] REFS_I,
    input wire logic [SELW-1:0] PLL_TWO_REF_SEL_I,
    input wire logic            I2C_ENABLE_I,
    input wire logic [1:0]      PLL_ONE_MODE_O,
    input wire logic            HITLESS_SWITCH_O,
    input wire logic            PHASE_REALIGN_O,
    input wire logic            LOCK_O,
    input wire logic            HOLD_O,
    input wire logic            REF_OUT_O,
    input wire logic            SO_O,
    input wire logic            SCL_O,
    input wire logic            SCL_OE_N_O,
    input wire logic            SDA_O,
    input wire logic            SDA_OE_N_O
);
    default clocking cb @(posedge REF_CLK_I); endclocking
    // pin pair and selected reference as plain nets for $past
    wire logic [1:0] pins = {PLL_MODE_PIN_BIT1_I, PLL_MODE_PIN_BIT0_I};
    wire logic       ref_pick = REFS_I[PLL_TWO_REF_SEL_I];

    chk_reset_quiet: assert property (!RST_N_I |=> !LOCK_O && !HOLD_O && !SO_O && SDA_OE_N_O)
        else $error("outputs not cleared in reset");
    chk_mode_strap: assert property (!RST_N_I |=> PLL_ONE_MODE_O == $past(pins))
        else $error("mode not strapped from pins");
    // pin change passes the mode register, then the output flop
    chk_mode_pins: assert property (disable iff (!RST_N_I) $past(RST_N_I) && pins != $past(pins) |=> ##1 PLL_ONE_MODE_O == $past(pins, 2))
        else $error("pin change not followed");
    // a request seen on the release edge is already registered by the running flops
    chk_switch_kind: assert property (disable iff (!RST_N_I) RST_N_I && REF_SWITCH_I |=> HITLESS_SWITCH_O != PHASE_REALIGN_O)
        else $error("switch not reported once");
    chk_switch_idle: assert property (disable iff (!RST_N_I) !REF_SWITCH_I |=> !HITLESS_SWITCH_O && !PHASE_REALIGN_O)
        else $error("switch pulse without cause");
    chk_lock_cause: assert property (disable iff (!RST_N_I) LOCK_O |-> $past(PLL_LOCKED_I))
        else $error("lock without loop lock");
    chk_lock_forced: assert property (disable iff (!RST_N_I) PLL_ONE_MODE_O[1] [*2] |-> !LOCK_O)
        else $error("lock high in holdover or free-run");
    chk_hold_mode: assert property (disable iff (!RST_N_I) (RST_N_I && PLL_ONE_MODE_O == `DPCS_MODE_HOLD) [*2] |-> HOLD_O)
        else $error("holdover mode not flagged");
    chk_ref_copy: assert property (disable iff (!RST_N_I) $past(RST_N_I) |-> REF_OUT_O == $past(ref_pick))
        else $error("reference output not a copy");
    chk_so_idle: assert property (disable iff (!RST_N_I) $past(I2C_ENABLE_I) |-> !SO_O)
        else $error("spi output active in i2c mode");
    chk_sda_spi: assert property (disable iff (!RST_N_I) !I2C_ENABLE_I && !$past(I2C_ENABLE_I) && !$past(I2C_ENABLE_I, 2) |-> SDA_OE_N_O)
        else $error("sda pulled in spi mode");
    chk_scl_released: assert property (disable iff (!RST_N_I) SCL_OE_N_O && !SCL_O && !SDA_O)
        else $error("scl driven or sda data level high");
    cover property (HITLESS_SWITCH_O);
    cover property (PHASE_REALIGN_O);
    cover property ($fell(SDA_OE_N_O));
endmodule // dpcs_checker

bind dpcs_top dpcs_checker #(.NREF(NREF), .SELW(SELW)) u_chk (
    .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I),
    .PLL_MODE_PIN_BIT0_I(PLL_MODE_PIN_BIT0_I),
    .PLL_MODE_PIN_BIT1_I(PLL_MODE_PIN_BIT1_I),
    .PLL_LOCKED_I(PLL_LOCKED_I), .REF_SWITCH_I(REF_SWITCH_I),
    .REFS_I(REFS_I), .PLL_TWO_REF_SEL_I(PLL_TWO_REF_SEL_I),
    .I2C_ENABLE_I(I2C_ENABLE_I), .PLL_ONE_MODE_O(PLL_ONE_MODE_O),
    .HITLESS_SWITCH_O(HITLESS_SWITCH_O), .PHASE_REALIGN_O(PHASE_REALIGN_O),
    .LOCK_O(LOCK_O), .HOLD_O(HOLD_O), .REF_OUT_O(REF_OUT_O), .SO_O(SO_O),
    .SCL_O(SCL_O), .SCL_OE_N_O(SCL_OE_N_O), .SDA_O(SDA_O),
    .SDA_OE_N_O(SDA_OE_N_O));
`default_nettype wire

/* dpcs_host_model.sv */
// Purpose: host processor driving the shared spi / i2c pins
// Assumes: three clocks per step; serial clock low for six clocks, high for three
// Notes:   i2c side covers address probes and register write and read
`timescale 1ns/10ps
`default_nettype none
module dpcs_host_model (
    input  wire logic clk_i,
    input  wire logic so_i,
    input  wire logic sda_i,
    output var  logic sck_o,
    output var  logic dat_o,
    output var  logic cs_n_o
);
    initial begin
        sck_o = 1'b0;
        dat_o = 1'b1;
        cs_n_o = 1'b1;
    end
    task automatic wt;
        repeat (3) @(posedge clk_i);
    endtask
    // spi frame: read flag, address, data, msb first, sck idle low
    task automatic spi(input logic rd, input logic [6:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        logic [15:0] w;
        w = {rd, a, d};
        q = 8'h00;
        cs_n_o <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            wt;
            dat_o <= w[i];
            wt;
            sck_o <= 1'b1;
            wt;
            if (i < 8) q[i] = so_i;
            sck_o <= 1'b0;
        end
        wt;
        cs_n_o <= 1'b1;
        dat_o <= ~dat_o; // released line must not keep its last level
        wt;
    endtask
    // one scl period: data set while scl low, line read while high
    task automatic i2c_bit(input logic b, output logic r);
        sck_o <= 1'b0;
        wt;
        dat_o <= b;
        wt;
        sck_o <= 1'b1;
        wt;
        r = sda_i;
    endtask
    // start or repeated start: sda falls while scl is high
    task automatic i2c_start;
        sck_o <= 1'b0;
        wt;
        dat_o <= 1'b1;
        wt;
        sck_o <= 1'b1;
        wt;
        dat_o <= 1'b0;
        wt;
    endtask
    // stop: sda rises while scl is high, bus left released
    task automatic i2c_stop;
        sck_o <= 1'b0;
        wt;
        dat_o <= 1'b0;
        wt;
        sck_o <= 1'b1;
        wt;
        dat_o <= 1'b1;
        wt;
    endtask
    // eight bits msb first, the ninth is the acknowledge slot
    task automatic i2c_byte(input logic [8:0] w, output logic [8:0] r);
        for (int i = 8; i >= 0; i--)
            i2c_bit(w[i], r[i]);
    endtask
    // start, address with write flag, ack slot, stop
    task automatic i2c(input logic [6:0] a, output logic ack);
        logic [8:0] r;
        i2c_start;
        i2c_byte({a, 2'h1}, r);
        ack = !r[0];
        i2c_stop;
    endtask
    // register write, or pointer then read of one byte ended by a nack
    task automatic i2c_xfer(input logic rd, input logic [6:0] a,
                            input logic [7:0] p, input logic [7:0] d,
                            output logic [7:0] q);
        logic [8:0] r;
        q = 8'h00;
        i2c_start;
        i2c_byte({a, 2'h1}, r);
        i2c_byte({p, 1'b1}, r);
        if (rd) begin
            i2c_start;
            i2c_byte({a, 2'h3}, r);
            i2c_byte(9'h1ff, r); // line released, slave drives the data
            q = r[8:1];
        end else begin
            i2c_byte({d, 1'b1}, r);
        end
        i2c_stop;
    endtask
endmodule // dpcs_host_model
`default_nettype wire

/* test_dpcs_top.sv */
// Purpose: self-checking bench of the pll control and host pin block
// Assumes: 50 MHz clock, seeded random pin traffic
// Notes:   expectations come from the bench function want and from fixed values in the bench
`timescale 1ns/10ps
`default_nettype none
`include "dpcs_consts.vh"
module test_dpcs_top;
    logic       ref_clk, rst_n, hs_pin, locked, holdover, ref_sw, i2c_en;
    logic       sck, dat, cs_n, so, sda_oe_n, ack, hs_o, ra_o, lock_o;
    logic       hold_o, ref_o;
    logic [1:0] mode_pins, mode_o;
    logic [7:0] refs, q;
    logic [2:0] sel, asel;
    int         error_cnt = 0, n_tests = 0, seed = 3183;
    wire logic  sda_line = dat & sda_oe_n; // open drain with pull-up

    dpcs_top #(.NREF(8), .SELW(3)) dut (
        .REF_CLK_I(ref_clk), .RST_N_I(rst_n),
        .HITLESS_SWITCH_ENABLE_I(hs_pin),
        .PLL_MODE_PIN_BIT0_I(mode_pins[0]), .PLL_MODE_PIN_BIT1_I(mode_pins[1]),
        .PLL_LOCKED_I(locked), .PLL_HOLDOVER_I(holdover),
        .REF_SWITCH_I(ref_sw), .REFS_I(refs), .PLL_TWO_REF_SEL_I(sel),
        .I2C_ENABLE_I(i2c_en), .SCK_SCL_I(sck), .SI_SDA_I(sda_line),
        .CHIP_SELECT_OR_ADDR_BIT0_I(i2c_en ? asel[0] : cs_n),
        .BUS_ADDR_PICK_BIT1_I(asel[1]), .BUS_ADDR_PICK_BIT2_I(asel[2]),
        .PLL_ONE_MODE_O(mode_o), .HITLESS_SWITCH_O(hs_o),
        .PHASE_REALIGN_O(ra_o), .LOCK_O(lock_o), .HOLD_O(hold_o),
        .REF_OUT_O(ref_o), .SO_O(so), .SCL_O(), .SCL_OE_N_O(), .SDA_O(),
        .SDA_OE_N_O(sda_oe_n));
    dpcs_host_model host (.clk_i(ref_clk), .so_i(so), .sda_i(sda_line),
        .sck_o(sck), .dat_o(dat), .cs_n_o(cs_n));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("errors=%0d tests=%0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // lock, hold, ref copy, hitless and realign pulses
    function automatic logic [7:0] want(logic [1:0] m, logic lk, logic ho,
                                        logic rf, logic sw, logic hs);
        return {3'h0, lk & ~m[1], m == `DPCS_MODE_HOLD |
                (m == `DPCS_MODE_AUTO & ho), rf, sw & hs, sw & ~hs};
    endfunction
    task automatic do_reset(input logic [1:0] m);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        mode_pins <= m;
        repeat (16) @(posedge ref_clk);
        #1;
        chk({lock_o, hold_o, ref_o, so, hs_o, ra_o, mode_o}, {6'h00, m});
        @(posedge ref_clk);
        rst_n <= 1'b1;
    endtask
    // one random cycle; sw_on picks the register over the pin
    task automatic rnd(input logic [1:0] m, input logic sw_on, input logic sw_v);
        logic [31:0] t;
        t = $random(seed);
        @(posedge ref_clk);
        {locked, holdover, ref_sw, hs_pin} <= t[3:0];
        refs <= t[15:8];
        sel <= t[18:16];
        @(posedge ref_clk);
        #1;
        chk({3'h0, lock_o, hold_o, ref_o, hs_o, ra_o}, want(m, t[3], t[2], t[8 + t[18:16]], t[1], sw_on ? sw_v : t[0]));
    endtask

    initial begin
        {rst_n, hs_pin, locked, holdover, ref_sw, i2c_en} = 6'h00;
        {mode_pins, refs, sel, asel} = 16'h0000;
        for (int m = 0; m < 4; m++) begin
            do_reset(m[1:0]);
            repeat (12) rnd(m[1:0], 1'b0, 1'b0);
        end
        host.spi(1'b1, 7'h20, 8'h00, q);
        chk(q, 8'h00);
        host.spi(1'b0, 7'h1f, 8'h02, q);
        chk({6'h00, mode_o}, {6'h00, `DPCS_MODE_HOLD});
        host.spi(1'b1, 7'h1f, 8'h00, q);
        chk(q, {6'h00, `DPCS_MODE_HOLD});
        repeat (8) rnd(`DPCS_MODE_HOLD, 1'b0, 1'b0);
        host.spi(1'b0, 7'h20, 8'h03, q);
        repeat (8) rnd(`DPCS_MODE_HOLD, 1'b1, 1'b1);
        host.spi(1'b0, 7'h20, 8'h02, q);
        repeat (8) rnd(`DPCS_MODE_HOLD, 1'b1, 1'b0);
        host.spi(1'b1, 7'h21, 8'h00, q);
        chk(q, 8'h04);
        host.spi(1'b0, 7'h05, 8'h5a, q);
        host.spi(1'b1, 7'h05, 8'h00, q);
        chk(q, 8'h00);
        host.spi(1'b0, 7'h20, 8'h00, q);
        // pin change after reset overrides the written mode
        @(posedge ref_clk);
        mode_pins <= `DPCS_MODE_NORMAL;
        // mode register, then output flop: two edges to show
        repeat (2) @(posedge ref_clk);
        #1;
        chk({6'h00, mode_o}, {6'h00, `DPCS_MODE_NORMAL});
        repeat (8) rnd(`DPCS_MODE_NORMAL, 1'b0, 1'b0);
        @(posedge ref_clk);
        i2c_en <= 1'b1;
        asel <= 3'h5;
        repeat (4) @(posedge ref_clk);
        host.i2c({`DPCS_I2C_ADDR_HI, 3'h5}, ack);
        chk({7'h00, ack}, 8'h01);
        host.i2c({`DPCS_I2C_ADDR_HI, 3'h4}, ack);
        chk({7'h00, ack}, 8'h00);
        // register write and read back through the i2c pointer
        host.i2c_xfer(1'b0, {`DPCS_I2C_ADDR_HI, 3'h5}, 8'h1f, 8'h03, q);
        chk({6'h00, mode_o}, {6'h00, `DPCS_MODE_FREE});
        host.i2c_xfer(1'b1, {`DPCS_I2C_ADDR_HI, 3'h5}, 8'h1f, 8'h00, q);
        chk(q, {6'h00, `DPCS_MODE_FREE});
        conclude;
    end
    // hang guard, far beyond the few thousand cycles the run needs
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        conclude;
    end
endmodule // test_dpcs_top
`default_nettype wire
